// [wake_frame_detector.sv]
// wake frame detector: ahb-lite registers, filter store, pattern crc matching
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`include "wake_cfg.svh"
`default_nettype none
module wake_frame_detector (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire wake_pkg::rx_beat_t rx_in,
  output wake_pkg::rx_beat_t rx_out,
  output logic remote_wakeup,
  output logic fully_operational,
  output logic irq
);
  import wake_pkg::*;

  wake_st_t q, d;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[15] ^ b[i]) begin
        r = {r[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_read(input wake_st_t s, input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `WAKE_CTRL_OFS: begin
        v[`WAKE_EN_BIT] = s.en;
        v[`WAKE_FLAG_BIT] = s.flag;
      end
      `WAKE_STORE_OFS: v = s.mem[s.ptr];
      `WAKE_IRQ_STAT_OFS: v[1:0] = s.irq_stat;
      `WAKE_IRQ_MASK_OFS: v[1:0] = s.irq_mask;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic [5:0] ptr_next(input logic [5:0] p);
    return (p == `STORE_LAST_PTR) ? 6'h0 : p + 6'h1;
  endfunction

  logic addr_sel;
  logic match;
  logic miss;
  logic [10:0] rel;
  logic [10:0] off;
  logic [5:0] word;

  always_comb begin
    d = q;
    match = 1'b0;
    miss = 1'b0;
    rel = 11'h0;
    off = 11'h0;
    word = 6'h0;
    d.wake = 1'b0;
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    // ***********************
    // bus slave
    // ***********************
    // write data arrives one cycle after its address phase
    if (q.pend_wr) begin
      d.pend_wr = 1'b0;
      case (q.pend_reg)
        2'h0: begin
          d.en = hwdata[`WAKE_EN_BIT];
          if (hwdata[`WAKE_FLAG_BIT]) begin
            d.flag = 1'b0;
          end
        end
        2'h1: begin
          d.mem[q.ptr] = hwdata;
          d.ptr = ptr_next(q.ptr);
        end
        2'h2: d.irq_stat = q.irq_stat & ~hwdata[1:0];
        default: d.irq_mask = hwdata[1:0];
      endcase
    end
    addr_sel = hsel && htrans[1] && hready;
    if (addr_sel && hwrite) begin
      d.pend_wr = 1'b1;
      d.pend_reg = haddr[3:2];
    end
    if (addr_sel && !hwrite) begin
      d.hrdata = reg_read(q, haddr[3:0]);
      if (haddr[3:0] == `WAKE_STORE_OFS) begin
        d.ptr = ptr_next(q.ptr);
      end
    end
    // ***********************
    // receive path
    // ***********************
    // normal delivery is cut off while detecting
    d.rx_out = rx_in;
    d.rx_out.valid = rx_in.valid && !q.en;
    d.rx_out.sof = rx_in.sof && !q.en;
    d.rx_out.eof = rx_in.eof && !q.en;
    case (q.rx_st)
      RX_IDLE: begin
        if (rx_in.sof) begin
          d.rx_st = RX_FRAME;
          d.cnt = 11'h0;
          for (int f = 0; f < 8; f++) begin
            d.crc[f] = `CRC_INIT;
          end
        end
      end
      RX_FRAME: begin
        if (rx_in.valid) begin
          // counter saturates; bytes past 2047 never reach a mask window
          if (q.cnt != 11'h7ff) begin
            d.cnt = q.cnt + 11'h1;
          end
          for (int f = 0; f < 8; f++) begin
            off = {3'h0, q.mem[`STORE_OFFSET_WORD + f / 4][8 * (f % 4) +: 8]};
            rel = q.cnt - off;
            word = 6'(4 * f) + {4'h0, rel[6:5]};
            if (q.cnt >= off && rel < 11'(`MASK_BYTES) && q.mem[word][rel[4:0]]) begin
              d.crc[f] = crc_byte(q.crc[f], rx_in.data);
            end
          end
        end
        if (rx_in.eof) begin
          d.rx_st = RX_IDLE;
          for (int f = 0; f < 8; f++) begin
            if (q.mem[`STORE_ENABLE_WORD][f] &&
                q.crc[f] == q.mem[`STORE_CRC_WORD + f / 2][16 * (f % 2) +: 16]) begin
              match = 1'b1;
            end
          end
          // only station-addressed frames in detect mode count
          match = match && rx_in.addr_pass && q.en;
          miss = !match && rx_in.addr_pass && q.en;
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase
    // ***********************
    // wake event and interrupts
    // ***********************
    if (match) begin
      d.flag = 1'b1;
      d.wake = 1'b1;
      d.oper = 1'b1;
    end else if (d.en && !q.en) begin
      d.oper = 1'b0;
    end else if (!d.en) begin
      d.oper = 1'b1;
    end
    // set wins over a simultaneous clear
    if (match) begin
      d.irq_stat[`IRQ_WAKE_BIT] = 1'b1;
    end
    if (miss) begin
      d.irq_stat[`IRQ_MISS_BIT] = 1'b1;
    end
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.irq_stat <= `IRQ_RST;
      q.irq_mask <= `IRQ_RST;
      q.hreadyout <= 1'b1;
      q.oper <= 1'b1;
      q.rx_st <= RX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign rx_out = q.rx_out;
  assign remote_wakeup = q.wake;
  assign fully_operational = q.oper;
  assign irq = q.irq;

  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_detect_blocks_rx: assert property (q.en |=> !q.rx_out.valid)
    else $error("frame delivered while detecting");
  a_wake_sets_flag: assert property ($rose(q.wake) |-> q.flag && q.oper)
    else $error("wakeup without flag or full operation");
  a_wake_one_cycle: assert property (q.wake |=> !q.wake)
    else $error("wakeup pulse longer than one cycle");
  a_wake_needs_mode: assert property (q.wake |-> $past(q.en))
    else $error("wakeup outside detection mode");
  a_clear_resumes: assert property ($fell(q.en) |-> q.oper ##1 q.rx_out.valid == $past(rx_in.valid))
    else $error("reception not resumed");
  a_store_ptr_wrap: assert property (q.ptr <= `STORE_LAST_PTR)
    else $error("store pointer beyond forty words");
  a_store_write_steps: assert property (q.pend_wr && q.pend_reg == 2'h1 |=>
      q.ptr == ptr_next($past(q.ptr)) || $past(addr_sel && !hwrite))
    else $error("store pointer not stepped on write");
  a_no_match_no_flag: assert property (!$past(q.flag) && q.flag |-> $past(q.rx_st == RX_FRAME)
      && $past(rx_in.eof && rx_in.addr_pass))
    else $error("flag set without qualified frame end");
  a_irq_follows: assert property (q.irq == |(q.irq_stat & q.irq_mask))
    else $error("interrupt level wrong");
  a_okay_only: assert property (q.hreadyout && !q.hresp)
    else $error("slave not ready or error response");

  c_wake_seen: cover property (q.en ##[1:1000] q.wake);
  c_miss_seen: cover property (q.en && miss);
  c_store_wrap: cover property (q.ptr == `STORE_LAST_PTR ##[1:20] q.ptr == 6'h0);
  c_resume: cover property (q.flag ##[1:100] !q.en && !q.flag);
endmodule
`default_nettype wire

// [wake_cfg.svh]
// register map, field positions, reset values and sizes of the wake frame detector
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH
// ***********************
// register byte offsets
// ***********************
`define WAKE_CTRL_OFS 4'h0
`define WAKE_STORE_OFS 4'h4
`define WAKE_IRQ_STAT_OFS 4'h8
`define WAKE_IRQ_MASK_OFS 4'hc
// ***********************
// control/status fields
// ***********************
`define WAKE_EN_BIT 0
`define WAKE_FLAG_BIT 1
`define IRQ_WAKE_BIT 0
`define IRQ_MISS_BIT 1
`define IRQ_RST 2'h0
// ***********************
// filter store layout
// ***********************
`define STORE_WORDS 40
`define STORE_ENABLE_WORD 32
`define STORE_OFFSET_WORD 33
`define STORE_CRC_WORD 35
`define STORE_LAST_PTR 6'h27
`define MASK_BYTES 128
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8005
`endif

// [wake_pkg.sv]
// types shared by the wake frame detector
`default_nettype none
package wake_pkg;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_FRAME = 1'b1} rx_state_t;
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic addr_pass;
    logic [7:0] data;
  } rx_beat_t;
  typedef struct packed {
    logic en;
    logic flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [5:0] ptr;
    logic [39:0][31:0] mem;
    rx_state_t rx_st;
    logic [10:0] cnt;
    logic [7:0][15:0] crc;
    logic pend_wr;
    logic [1:0] pend_reg;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rx_beat_t rx_out;
    logic wake;
    logic oper;
    logic irq;
  } wake_st_t;
endpackage
`default_nettype wire

// [wake_rx_source.sv]
// receive beat source standing in for the mac receive path
`default_nettype none
module wake_rx_source (
  input wire logic hclk,
  output var wake_pkg::rx_beat_t rx_in
);
  import wake_pkg::*;
  // ****
  // frame playback
  // ****
  logic [7:0] fb [0:19];
  initial rx_in = '0;
  // eof and idle data show the inverse of the last byte; the sof beat inverts the data before it
  task automatic send(input int n, input logic ap);
    @(posedge hclk) rx_in <= {4'h4, ~rx_in.data};
    for (int i = 0; i < n; i++) begin
      @(posedge hclk) rx_in <= {4'h8, fb[i]};
    end
    @(posedge hclk) rx_in <= {3'h1, ap, ~fb[n - 1]};
    @(posedge hclk) rx_in <= {4'h0, ~fb[n - 1]};
  endtask
endmodule
`default_nettype wire

// [test_wake_frame_detector.sv]
// self-checking bench for the wake frame detector
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_wake_frame_detector;
  timeunit 1ns;
  timeprecision 1ps;
  import wake_pkg::*;
  // ****
  // stimulus and monitors
  // ****
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp, rwu, fop, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val, ex, msk;
  logic [15:0] crc;
  logic [31:0] st [0:39];
  logic [31:0] q [$];
  rx_beat_t rx_in, rx_out;
  int failures = 0, n_checks = 0, cyc = 0, seed = 22733, wakes = 0, outs = 0;
  event rd_ev;
  initial forever #25 hclk = ~hclk;
  wake_frame_detector i_wake_frame_detector (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
    .rx_out(rx_out), .remote_wakeup(rwu), .fully_operational(fop), .irq(irq));
  wake_rx_source i_wake_rx_source (.hclk(hclk), .rx_in(rx_in));
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // starts at the next rising edge; no wait count assumed
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
    if (!w) ->rd_ev;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = c[15] ^ b[i] ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    return c;
  endfunction
  // filter 0 carries a wrong crc, filter 7 the right one
  task automatic prog(input logic [7:0] en);
    for (int i = 0; i < 40; i++) begin
      st[i] = (i == 0 || i == 28) ? msk : 32'h0;
      if (i == 32) st[i] = {24'h0, en};
      if (i == 33) st[i] = 32'h2;
      if (i == 34) st[i] = 32'h0200_0000;
      if (i == 35) st[i] = {16'h0, crc ^ 16'h1};
      if (i == 38) st[i] = {crc, 16'h0};
      wr(4'h4, st[i]);
    end
  endtask
  task automatic frame(input logic ap);
    i_wake_rx_source.send(20, ap);
    repeat (4) @(negedge hclk);
  endtask
  always @(posedge hclk) begin
    cyc++;
    wakes += (rwu === 1'b1);
    outs += (rx_out.valid === 1'b1);
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  always @(rd_ev) begin
    ex = q.pop_front();
    `CHK(rd_val, ex)
    `CHK(hresp, 1'b0)
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK(fop, 1'b1)
    rd(4'h0, 32'h0);
    rd(4'hc, 32'h0);
    for (int i = 0; i < 40; i++) begin
      st[i] = $random(seed);
      wr(4'h4, st[i]);
    end
    for (int i = 0; i < 40; i++) rd(4'h4, st[i]);
    msk = $random(seed);
    crc = 16'hffff;
    for (int i = 0; i < 20; i++) begin
      i_wake_rx_source.fb[i] = 8'($random(seed));
      if (i >= 2 && msk[i - 2]) crc = crc_upd(crc, i_wake_rx_source.fb[i]);
    end
    frame(1'b1);
    `CHK(outs, 20)
    wr(4'h8, 32'h3);
    prog(8'h01);
    wr(4'h0, 32'h1);
    frame(1'b1);
    `CHK(fop, 1'b0)
    `CHK(outs, 20)
    `CHK(wakes, 0)
    `CHK(irq, 1'b0)
    wr(4'h0, 32'h0);
    prog(8'h80);
    wr(4'h0, 32'h1);
    frame(1'b0);
    `CHK(wakes, 0)
    wr(4'hc, 32'h1);
    frame(1'b1);
    `CHK(wakes, 1)
    `CHK(fop, 1'b1)
    `CHK(irq, 1'b1)
    rd(4'h0, 32'h3);
    rd(4'h8, 32'h3);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h2);
    rd(4'h0, 32'h0);
    rd(4'h4, st[0]);
    frame(1'b1);
    `CHK(outs, 40)
    `CHK(wakes, 1)
    `CHK(irq, 1'b0)
    wr(4'hc, 32'h2);
    @(negedge hclk);
    `CHK(irq, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
